/* File: design/eep_defines.svh */
// Constants of the serial EEPROM slave: codes, widths, reset values, timing.
// Assumes inclusion by bare name from the design files.
`ifndef EEP_DEFINES_SVH
`define EEP_DEFINES_SVH

// Device-type code in the upper nibble of the control byte
`define EEP_TYPE_CODE     4'hA
// Array geometry
`define EEP_ADDR_W        13
`define EEP_DATA_W        8
// Reset value of the address pointer
`define EEP_PTR_RESET     13'h0000
// Main clock rate and self-timed write cycle
`define EEP_MCLK_KHZ      10000
`define EEP_WRITE_TIME_US 5000
`define EEP_WRITE_CYCLES  ((`EEP_WRITE_TIME_US * `EEP_MCLK_KHZ) / 1000)

`endif

/* File: design/eep_pkg.sv */
// Types shared by the serial EEPROM slave.
// Assumes nothing of its surroundings.
package eep_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b010,
    ST_TX   = 3'b011,
    ST_MACK = 3'b100
  } eep_state_t;

  typedef enum logic [1:0] {
    K_CTRL = 2'b00,
    K_AHI  = 2'b01,
    K_ALO  = 2'b10,
    K_DATA = 2'b11
  } eep_kind_t;

endpackage

/* File: design/eep_sync.sv */
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a level or a toggle that stays put for two clocks.
`timescale 1ns/10ps
module eep_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock, reset, enable
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             en,
  // Levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  generate
    if (WIDTH < 1) begin : g_bad
      $error("eep_sync: WIDTH must be at least 1");
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else if (en) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // eep_sync

/* File: design/eep_mem.sv */
// Byte array of the EEPROM with one write port and a registered read port.
// Assumes one clock; read data follow the read address by one edge.
`timescale 1ns/10ps
module eep_mem #(
  parameter int unsigned AW = 13,
  parameter int unsigned DW = 8
) (
  // Clock and enable
  input  wire logic          clk,
  input  wire logic          en,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  generate
    if (AW < 1 || AW > 20 || DW < 1) begin : g_bad
      $error("eep_mem: unsupported AW or DW");
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (en && we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (en) begin
      rdata <= mem_q[raddr];
    end
  end

endmodule // eep_mem

/* File: design/eep_serial_top.sv */
// Two-wire serial slave of an 8-kbyte EEPROM: addressing, reads, polling.
// Assumes an external pull-up resolves SDA from SDA_OE; LINK_CLK samples
// the bus several times per SCL phase; MCLK times the write cycle.
`timescale 1ns/10ps
`include "eep_defines.svh"

// Function
// - No acknowledge while write cycle runs
// - Acknowledge matching control byte once idle
// - Direction bit one selects read
// - Pointer holds last location plus one
// - Ack read control, send byte MSB first
// - Restart after address aborts, keeps pointer
// - Pointer follows byte returned by read
// - Master ack sends next sequential byte
// - Pointer increments after every data byte
// - Pointer wraps from top to zero
// - Respond only if chip-select pins match
// - Data line only pulled low or released
// - Data changes only while clock low
// - Write-protect high inhibits all writes
// - Write-protect low allows full access
// - Control byte: type, chip select, direction
// - Address high byte first, 13 bits used
// - Release line after master nack
module eep_serial_top
  import eep_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `EEP_WRITE_CYCLES,
  parameter int unsigned ADDR_W       = `EEP_ADDR_W
) (
  // Main clock domain
  input  wire logic MCLK,
  input  wire logic RST,
  input  wire logic CE,
  // Bus sampling clock
  input  wire logic LINK_CLK,
  // Serial bus
  input  wire logic SCL,
  input  wire logic SDA_I,
  output logic      SDA_O,
  output logic      SDA_OE,
  // Straps
  input  wire logic CHIP_SELECT_IN_0,
  input  wire logic CHIP_SELECT_IN_1,
  input  wire logic CHIP_SELECT_IN_2,
  input  wire logic WRITE_PROTECT
);

  localparam int unsigned CNT_W = $clog2(WRITE_CYCLES + 1);

  generate
    if (ADDR_W != `EEP_ADDR_W || WRITE_CYCLES < 2) begin : g_bad
      $error("eep_serial_top: unsupported ADDR_W or WRITE_CYCLES");
    end
  endgenerate
  // Link-side synchronised inputs
  logic [7:0]        sync_in, sync_out;
  logic [2:0]        cs_s;
  logic              scl_s, sda_s, wp_s, ce_l, done_l, scl_p_q, sda_p_q;
  // Link-side protocol state
  eep_state_t        state_q;
  eep_kind_t         kind_q;
  logic [3:0]        bit_q;
  logic [7:0]        sh_q, wdata_q, rd_data;
  logic [ADDR_W-1:0] ptr_q, waddr_q;
  logic              sda_oe_q, rd_dir_q, wpend_q, mem_we_q, req_tog_q;
  // Decisions
  logic              start_det, stop_det, scl_rise, scl_fall, busy_l;
  logic              ctrl_match, byte_end, ack_end, load_tx;
  // Main-side write timer
  logic              req_m, done_tog_q;
  logic [CNT_W-1:0]  cnt_q;
  assign sync_in = {SCL, SDA_I, CHIP_SELECT_IN_2, CHIP_SELECT_IN_1,
                    CHIP_SELECT_IN_0, WRITE_PROTECT, CE, done_tog_q};

  eep_sync #(.WIDTH(8)) u_link_sync (
    .clk (LINK_CLK),
    .rst (RST),
    .en  (1'b1),
    .d   (sync_in),
    .q   (sync_out)
  );

  assign scl_s  = sync_out[7];
  assign sda_s  = sync_out[6];
  assign cs_s   = sync_out[5:3];
  assign wp_s   = sync_out[2];
  assign ce_l   = sync_out[1];
  assign done_l = sync_out[0];

  // Previous samples for edge and condition detection
  always_ff @(posedge LINK_CLK or posedge RST) begin
    if (RST) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (ce_l) begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign scl_rise  = scl_s & ~scl_p_q;
  assign scl_fall  = ~scl_s & scl_p_q;
  assign busy_l    = req_tog_q ^ done_l;

  assign ctrl_match = (sh_q[7:4] == `EEP_TYPE_CODE)
                    && (sh_q[3:1] == cs_s)
                    && !busy_l;
  assign byte_end = (state_q == ST_RX) && scl_fall && (bit_q == 4'h8);
  assign ack_end  = (state_q == ST_ACK) && scl_fall;
  assign load_tx  = (ack_end && kind_q == K_CTRL && rd_dir_q)
                  || ((state_q == ST_MACK) && scl_fall);

  // Protocol sequencer; all line changes happen on SCL falls
  always_ff @(posedge LINK_CLK or posedge RST) begin
    if (RST) begin
      state_q  <= ST_IDLE;
      kind_q   <= K_CTRL;
      bit_q    <= 4'h0;
      sh_q     <= 8'h00;
      sda_oe_q <= 1'b0;
      rd_dir_q <= 1'b0;
    end else if (ce_l) begin
      if (start_det) begin
        state_q  <= ST_RX;
        kind_q   <= K_CTRL;
        bit_q    <= 4'h0;
        sda_oe_q <= 1'b0;
      end else if (stop_det) begin
        state_q  <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            sda_oe_q <= 1'b0;
          end
          ST_RX: begin
            if (scl_rise && bit_q != 4'h8) begin
              sh_q  <= {sh_q[6:0], sda_s};
              bit_q <= bit_q + 4'h1;
            end else if (byte_end) begin
              bit_q <= 4'h0;
              if (kind_q == K_CTRL && !ctrl_match) begin
                state_q <= ST_IDLE;
              end else begin
                state_q  <= ST_ACK;
                sda_oe_q <= 1'b1;
                if (kind_q == K_CTRL) begin
                  rd_dir_q <= sh_q[0];
                end
              end
            end
          end
          ST_ACK: begin
            if (load_tx) begin
              state_q  <= ST_TX;
              sh_q     <= rd_data;
              sda_oe_q <= ~rd_data[7];
              bit_q    <= 4'h1;
            end else if (scl_fall) begin
              state_q  <= ST_RX;
              sda_oe_q <= 1'b0;
              unique case (kind_q)
                K_CTRL:  kind_q <= K_AHI;
                K_AHI:   kind_q <= K_ALO;
                K_ALO:   kind_q <= K_DATA;
                K_DATA:  kind_q <= K_DATA;
              endcase
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_q == 4'h8) begin
                sda_oe_q <= 1'b0;
                state_q  <= ST_MACK;
              end else begin
                sda_oe_q <= ~sh_q[6];
                sh_q     <= {sh_q[6:0], 1'b0};
                bit_q    <= bit_q + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise && sda_s) begin
              state_q <= ST_IDLE;
            end else if (load_tx) begin
              state_q  <= ST_TX;
              sh_q     <= rd_data;
              sda_oe_q <= ~rd_data[7];
              bit_q    <= 4'h1;
            end
          end
          default: begin
            state_q  <= ST_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Address pointer
  always_ff @(posedge LINK_CLK or posedge RST) begin
    if (RST) begin
      ptr_q <= `EEP_PTR_RESET;
    end else if (ce_l) begin
      if (byte_end && kind_q == K_AHI) begin
        ptr_q[ADDR_W-1:8] <= sh_q[ADDR_W-9:0];
      end else if (byte_end && kind_q == K_ALO) begin
        ptr_q[7:0] <= sh_q;
      end else if (byte_end && kind_q == K_DATA) begin
        ptr_q <= ptr_q + 1'b1;
      end else if (load_tx) begin
        ptr_q <= ptr_q + 1'b1;
      end
    end
  end

  // Write capture and commit at Stop
  always_ff @(posedge LINK_CLK or posedge RST) begin
    if (RST) begin
      wpend_q   <= 1'b0;
      waddr_q   <= '0;
      wdata_q   <= 8'h00;
      mem_we_q  <= 1'b0;
      req_tog_q <= 1'b0;
    end else if (ce_l) begin
      mem_we_q <= 1'b0;
      if (start_det) begin
        wpend_q <= 1'b0;
      end else if (stop_det) begin
        wpend_q <= 1'b0;
        if (wpend_q && !wp_s) begin
          mem_we_q  <= 1'b1;
          req_tog_q <= ~req_tog_q;
        end
      end else if (byte_end && kind_q == K_DATA) begin
        wpend_q <= 1'b1;
        waddr_q <= ptr_q;
        wdata_q <= sh_q;
      end
    end
  end

  eep_mem #(.AW(ADDR_W), .DW(8)) u_mem (
    .clk   (LINK_CLK),
    .en    (ce_l),
    .we    (mem_we_q),
    .waddr (waddr_q),
    .wdata (wdata_q),
    .raddr (ptr_q),
    .rdata (rd_data)
  );

  assign SDA_O  = 1'b0;
  assign SDA_OE = sda_oe_q;
  // Self-timed write cycle on the main clock
  eep_sync #(.WIDTH(1)) u_req_sync (
    .clk (MCLK),
    .rst (RST),
    .en  (CE),
    .d   (req_tog_q),
    .q   (req_m)
  );

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cnt_q      <= '0;
      done_tog_q <= 1'b0;
    end else if (CE) begin
      if (cnt_q == '0 && req_m != done_tog_q) begin
        cnt_q <= CNT_W'(WRITE_CYCLES);
      end else if (cnt_q == CNT_W'(1)) begin
        cnt_q      <= '0;
        done_tog_q <= ~done_tog_q;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
    end
  end

  // Checks
  a_busy_no_ack: assert property (@(posedge LINK_CLK) disable iff (RST)
    (byte_end && kind_q == K_CTRL && busy_l && ce_l) |=> !sda_oe_q)
    else $error("control byte acknowledged during write cycle");
  a_ack_match: assert property (@(posedge LINK_CLK) disable iff (RST)
    (byte_end && kind_q == K_CTRL && ce_l && sda_oe_q == 1'b0 &&
     !$past(start_det)) ##1 (state_q == ST_ACK)
    |-> ($past(sh_q[7:4]) == `EEP_TYPE_CODE && $past(sh_q[3:1]) == cs_s))
    else $error("acknowledge given to mismatching control byte");
  a_ptr_step: assert property (@(posedge LINK_CLK) disable iff (RST)
    (load_tx && ce_l && !start_det && !stop_det)
    |=> ptr_q == $past(ptr_q) + 1'b1)
    else $error("pointer did not advance after byte");
  a_tx_msb: assert property (@(posedge LINK_CLK) disable iff (RST)
    (load_tx && ce_l && !start_det && !stop_det)
    |=> (state_q == ST_TX) && (sda_oe_q == !$past(rd_data[7])))
    else $error("first bit sent is not the MSB");
  a_oe_scl_low: assert property (@(posedge LINK_CLK) disable iff (RST)
    ($changed(sda_oe_q) && !$past(start_det) && !$past(stop_det))
    |-> !$past(scl_s))
    else $error("data line changed while clock high");
  a_nack_release: assert property (@(posedge LINK_CLK) disable iff (RST)
    (state_q == ST_MACK && scl_rise && sda_s && ce_l && !stop_det)
    |=> ((state_q == ST_IDLE) && !sda_oe_q) [*2])
    else $error("line not released after master nack");
  a_wp_block: assert property (@(posedge LINK_CLK) disable iff (RST)
    (stop_det && wp_s && ce_l) |=> !mem_we_q && $stable(req_tog_q))
    else $error("write performed while protected");
  a_restart_abort: assert property (@(posedge LINK_CLK) disable iff (RST)
    (start_det && ce_l) |=> !mem_we_q && !wpend_q && $stable(ptr_q))
    else $error("repeated start did not abort write");
  a_write_time: assert property (@(posedge MCLK) disable iff (RST)
    (cnt_q == '0 && req_m != done_tog_q && CE)
    |=> (cnt_q == CNT_W'(WRITE_CYCLES)) && $stable(done_tog_q))
    else $error("write cycle timer did not start");
  c_read_byte: cover property (@(posedge LINK_CLK) disable iff (RST)
    state_q == ST_MACK && scl_rise && !sda_s);
  c_write_commit: cover property (@(posedge LINK_CLK) disable iff (RST)
    mem_we_q);
  c_poll_refused: cover property (@(posedge LINK_CLK) disable iff (RST)
    byte_end && kind_q == K_CTRL && busy_l);
  c_wrap: cover property (@(posedge LINK_CLK) disable iff (RST)
    load_tx && ptr_q == '1);

endmodule // eep_serial_top

/* File: testbench/eep_master.sv */
// Behavioural two-wire bus master driving SCL and pulling SDA low.
// Assumes SDA is resolved outside with a pull-up from both pull-down enables.
`timescale 1ns/10ps
module eep_master (
  // Bus
  output logic      scl,
  output logic      oe,
  input  wire logic sda
);
  // Quarter of an SCL period, well above the slave's sampling needs
  localparam time Q = 250;

  initial begin
    scl = 1'b1;
    oe  = 1'b0;
  end

  // Falling SDA while SCL high; also used as repeated start
  task automatic start();
    oe = 1'b0;
    #Q scl = 1'b1;
    #Q oe = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask

  task automatic stop();
    oe = 1'b1;
    #Q scl = 1'b1;
    #Q oe = 1'b0;
    #Q;
  endtask

  // Data moves only while SCL low; released line reads high
  task automatic bitx(input logic b, output logic r);
    oe = ~b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask

  // Byte out MSB first, then the slave's acknowledge
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], r);
    end
    bitx(1'b1, r);
    ack = ~r;
  endtask

  // Byte in, then acknowledge or withhold it
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, d[i]);
    end
    bitx(~mack, r);
  endtask
endmodule // eep_master

/* File: testbench/eeprom_serial_read_and_poll_tb.sv */
// Self-checking bench of the serial EEPROM slave with a bus master model.
// Assumes the slave accepts 1 us SCL periods sampled by a 48 ns link clock.
`timescale 1ns/10ps
module eeprom_serial_read_and_poll_tb;
  import eep_pkg::*;

  typedef struct packed {
    logic [15:0] ad;
    logic [7:0]  d;
  } eep_row_t;

  localparam logic [2:0] CSV   = 3'h5;
  localparam int         LIMIT = 40000;

  logic       mclk;
  logic       link_clk;
  logic       rst;
  logic       ce;
  logic [2:0] cs;
  logic       wp;
  logic       scl;
  logic       m_oe;
  logic       sda_o;
  logic       sda_oe;
  wire        sda = ~(m_oe | sda_oe);
  int         num_errors;
  int         tests_run;
  int         cyc;
  int         nk;
  logic       a;
  logic [7:0] d;
  eep_row_t   rows [5];

  eep_serial_top #(.WRITE_CYCLES(200)) dut (
    .MCLK(mclk), .RST(rst), .CE(ce), .LINK_CLK(link_clk), .SCL(scl),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
    .CHIP_SELECT_IN_0(cs[0]), .CHIP_SELECT_IN_1(cs[1]),
    .CHIP_SELECT_IN_2(cs[2]), .WRITE_PROTECT(wp)
  );

  eep_master m (.scl(scl), .oe(m_oe), .sda(sda));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      num_errors++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h got %h", what, e, g);
      num_errors++;
    end
  endtask

  task automatic ctl(input logic rd, input logic [3:0] ty, output logic ak);
    m.start();
    m.wbyte({ty, CSV, rd}, ak);
  endtask

  task automatic set_ptr(input logic [15:0] ad);
    logic a1;
    logic a2;
    logic a3;
    ctl(1'b0, 4'hA, a1);
    m.wbyte(ad[15:8], a2);
    m.wbyte(ad[7:0], a3);
    chk("address acks", 16'h0001, {15'h0000, a1 & a2 & a3});
  endtask

  // Byte write, then poll; first poll may be a read control
  task automatic wr(input logic [15:0] ad, input logic [7:0] v,
                    input logic rd0, output int nacks);
    logic ak;
    set_ptr(ad);
    m.wbyte(v, ak);
    m.stop();
    nacks = 0;
    ctl(rd0, 4'hA, ak);
    while (!ak && nacks < 40) begin
      nacks++;
      ctl(1'b0, 4'hA, ak);
    end
    m.stop();
  endtask

  task automatic rd_rand(input logic [15:0] ad, input logic mack,
                         output logic [7:0] v);
    logic ak;
    set_ptr(ad);
    ctl(1'b1, 4'hA, ak);
    chk("read ctrl ack", 16'h0001, {15'h0000, ak});
    m.rbyte(mack, v);
  endtask

  initial begin
    num_errors = 0;
    tests_run  = 0;
    cyc        = 0;
    rst        = 1'b1;
    ce         = 1'b1;
    cs         = CSV;
    wp         = 1'b0;
    rows = '{'{16'h0000, 8'h5A}, '{16'h1FFF, 8'hC3}, '{16'hE005, 8'h81},
             '{16'h0006, 8'h7E}, '{16'h0001, 8'h3C}};
    repeat (6) @(negedge mclk);
    chk("oe in reset", 16'h0000, {14'h0000, sda_o, sda_oe});
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    foreach (rows[i]) begin
      wr(rows[i].ad, rows[i].d, i == 0, nk);
      chk("busy refused", 16'h0001, {15'h0000, nk > 0 && nk < 40});
      rd_rand(rows[i].ad, 1'b0, d);
      m.stop();
      chk("random read", {8'h00, rows[i].d}, {8'h00, d});
    end
    // Pointer left one past the random read
    rd_rand(16'h0005, 1'b0, d);
    m.stop();
    chk("alias read", 16'h0081, {8'h00, d});
    ctl(1'b1, 4'hA, a);
    m.rbyte(1'b0, d);
    #300;
    chk("released", 16'h0000, {15'h0000, sda_oe});
    m.stop();
    chk("current read", 16'h007E, {8'h00, d});
    // Sequential read wrapping from the top
    rd_rand(16'h1FFF, 1'b1, d);
    chk("seq top", 16'h00C3, {8'h00, d});
    m.rbyte(1'b1, d);
    chk("seq wrap", 16'h005A, {8'h00, d});
    m.rbyte(1'b0, d);
    m.stop();
    chk("seq next", 16'h003C, {8'h00, d});
    // Wrong chip select and wrong type are ignored
    @(negedge mclk);
    cs = CSV ^ 3'h1;
    ctl(1'b0, 4'hA, a);
    chk("cs mismatch", 16'h0000, {15'h0000, a});
    // A byte matching the new straps must still be ignored
    m.wbyte({4'hA, CSV ^ 3'h1, 1'b0}, a);
    chk("ignored after", 16'h0000, {15'h0000, a});
    m.stop();
    @(negedge mclk);
    cs = CSV;
    ctl(1'b0, 4'hB, a);
    m.stop();
    chk("type mismatch", 16'h0000, {15'h0000, a});
    // Protected write: acked, no busy, nothing stored
    @(negedge mclk);
    wp = 1'b1;
    wr(16'h0005, 8'hFF, 1'b0, nk);
    chk("wp no busy", 16'h0000, nk[15:0]);
    rd_rand(16'h0005, 1'b0, d);
    m.stop();
    chk("wp kept", 16'h0081, {8'h00, d});
    @(negedge mclk);
    wp = 1'b0;
    // Enable low freezes the link logic: no acknowledge
    ce = 1'b0;
    repeat (2) @(negedge mclk);
    ctl(1'b0, 4'hA, a);
    m.stop();
    chk("ce frozen", 16'h0000, {15'h0000, a});
    @(negedge mclk);
    ce = 1'b1;
    // Mid-run reset returns the pointer to zero, memory kept
    rst = 1'b1;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    chk("oe after reset", 16'h0000, {15'h0000, sda_oe});
    repeat (4) @(negedge mclk);
    ctl(1'b1, 4'hA, a);
    m.rbyte(1'b0, d);
    m.stop();
    chk("ack after reset", 16'h0001, {15'h0000, a});
    chk("ptr after reset", 16'h005A, {8'h00, d});
    results();
  end
endmodule // eeprom_serial_read_and_poll_tb
